// File: hdl/dac_front_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the dac front end
// Assumes: 32-bit apb data, mclk at 10 MHz
// Notes: included by bare name, definitions only
//
// What this block does
// - every serial transfer is gathered in a sixteen-bit shift register first
// - holding register fed by the link, separate output register drives conversion
// - word is three control bits, ten code bits, three sub-bits, msb first
// - ten code bits are an unsigned level from zero to 1023
// - control bits all ones enter shutdown, other bits ignored
// - shutdown disables the output amplifier and the reference input
// - serial words are still accepted and decoded during shutdown
// - holding register keeps its value through shutdown
// - shutdown ends by recall from holding or by loading new code directly
// - commands load holding only, load output directly, or copy holding to output
// - select is active low and enables the interface only while low
// - x00 load both, x01 holding only, x10 recall, 111 shutdown, 011 nothing
// - data is shifted in on each of the first sixteen rising serial clock edges while select is low
// - power-up clears holding and output registers to zero code
`ifndef DAC_FRONT_MAP_SVH
`define DAC_FRONT_MAP_SVH
`define CMD_OFFSET 8'h00
`define HOLD_OFFSET 8'h04
`define OUT_OFFSET 8'h08
`define STAT_OFFSET 8'h0c
`define CTRL_MSB 15
`define CTRL_LSB 13
`define CODE_MSB 12
`define CODE_LSB 3
`define STAT_SHUT_BIT 0
`define STAT_SETTLED_BIT 1
`define CODE_RESET 13'h0000
`define FRAME_BITS 5'h10
`define MCLK_PERIOD_NS 100
`define SETTLE_TIME_NS 20000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// File: hdl/dac_front_pkg.sv
// Purpose: types shared by the dac front end files
// Assumes: nothing beyond the map header
// Notes: action decode lives here so both views agree
package dac_front_pkg;
    typedef logic [15:0] serial_word_type;
    typedef struct packed {
        logic [9:0] codeBits;
        logic [2:0] subBits;
    } dac_code_type;
    typedef enum logic [2:0] {ACT_NONE, ACT_LOAD_BOTH, ACT_LOAD_HOLD, ACT_RECALL,
        ACT_SHUTDOWN} action_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_resp_type;
    typedef struct packed {
        dac_code_type level;
        logic outputDisable;
        logic refDisable;
        logic settled;
    } analog_ctrl_type;

    function automatic action_type decode_action(input logic [2:0] ctrl);
        action_type act;
        act = ACT_NONE;
        unique case (ctrl[1:0])
            2'h0: act = ACT_LOAD_BOTH;
            2'h1: act = ACT_LOAD_HOLD;
            2'h2: act = ACT_RECALL;
            2'h3: act = ctrl[2] ? ACT_SHUTDOWN : ACT_NONE;
        endcase
        return act;
    endfunction : decode_action
endpackage : dac_front_pkg

// File: hdl/link_shift_receiver.sv
// Purpose: serial link capture on the host's clock
// Assumes: the serial clock stands still while select is high
// Notes: a full word is handed over as held data plus a toggle
`timescale 1ns/1ps
`include "dac_front_map.svh"
module link_shift_receiver import dac_front_pkg::*; (
    input wire logic linkClk,
    input wire logic reset_n,
    input wire logic selectN,
    input wire logic dataIn,
    output serial_word_type wordHold,
    output logic wordToggle
);
    typedef struct packed {
        logic [4:0] count;
        serial_word_type shift;
    } frame_state_type;
    typedef struct packed {
        serial_word_type hold;
        logic toggle;
    } capture_state_type;

    frame_state_type frame_reg, frame_next;
    capture_state_type cap_reg, cap_next;
    logic frameRst_n;
    serial_word_type shifted;

    // select high holds the frame logic in reset, so a partial word never survives
    assign frameRst_n = reset_n & ~selectN;
    assign shifted = {frame_reg.shift[14:0], dataIn};

    always_comb begin
        frame_next = frame_reg;
        cap_next = cap_reg;
        if (frame_reg.count != `FRAME_BITS) begin
            frame_next.shift = shifted;
            frame_next.count = frame_reg.count + 5'h01;
            if (frame_reg.count == (`FRAME_BITS - 5'h01)) begin
                cap_next.hold = shifted;
                cap_next.toggle = ~cap_reg.toggle;
            end
        end
    end

    // edges beyond the sixteenth are ignored; the word stays as first received
    always_ff @(posedge linkClk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            cap_reg <= '0;
        end else begin
            cap_reg <= cap_next;
        end
    end

    assign wordHold = cap_reg.hold;
    assign wordToggle = cap_reg.toggle;

    // the link clock stops after a frame, so the next edge comes with select high in
    // between: only the block reset may disable this check
    chk_sixteen_edges: assert property (@(posedge linkClk) disable iff (!reset_n)
        frame_reg.count == 5'h0f |=> wordToggle != $past(wordToggle) && wordHold[0] == $past(dataIn))
        else $error("word not captured on sixteenth edge");
endmodule : link_shift_receiver

// File: hdl/serial_dac_command_front_end.sv
// Purpose: command front end of a 10-bit serial dac with apb register view
// Assumes: mclk 10 MHz, link clock unrelated in phase, select idle high
// Notes: serial and apb commands share one decoder; serial wins a collision
`timescale 1ns/1ps
`include "dac_front_map.svh"
module serial_dac_command_front_end import dac_front_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic selectN,
    input wire logic dataIn,
    input wire apb_req_type apbReq,
    output apb_resp_type apbResp,
    output analog_ctrl_type analogCtrl
);
    localparam logic [7:0] SETTLE_COUNT = 8'(`SETTLE_CYCLES);

    typedef struct packed {
        logic [3:0] syncSel;
        logic [2:0] syncTog;
        logic wordSeen;
        dac_code_type holdCode;
        dac_code_type outCode;
        logic shutdown;
        logic [7:0] settleCnt;
        logic settled;
        serial_word_type lastWord;
        logic [31:0] readData;
        logic readErr;
    } front_state_type;

    front_state_type st_reg, st_next;

    serial_word_type wordHold;
    logic wordToggle;
    logic selRise;
    logic togChange;
    logic execSerial;
    logic execApb;
    logic apbAccess;
    logic addrHit;
    serial_word_type execWord;
    action_type act;

    link_shift_receiver u_link (
        .linkClk(linkClk),
        .reset_n(reset_n),
        .selectN(selectN),
        .dataIn(dataIn),
        .wordHold(wordHold),
        .wordToggle(wordToggle)
    );

    // bit 0 of each chain is the first flop and feeds only bit 1.
    // select is one stage longer than the toggle so a finished word is
    // always seen before the select edge that closes its frame.
    assign togChange = st_reg.syncTog[2] ^ st_reg.syncTog[1];
    assign selRise = st_reg.syncSel[2] & ~st_reg.syncSel[3];
    assign execSerial = selRise & (st_reg.wordSeen | togChange);

    assign apbAccess = apbReq.psel & apbReq.penable;
    assign addrHit = (apbReq.paddr == `CMD_OFFSET) || (apbReq.paddr == `HOLD_OFFSET)
        || (apbReq.paddr == `OUT_OFFSET) || (apbReq.paddr == `STAT_OFFSET);
    // an apb command in the cycle of a serial command is stalled, not lost
    assign execApb = apbAccess & apbReq.pwrite & ~execSerial
        & (apbReq.paddr == `CMD_OFFSET);
    // wordHold is stable here: it changed before the toggle that was synchronised
    assign execWord = execSerial ? wordHold : apbReq.pwdata[15:0];
    assign act = (execSerial | execApb)
        ? decode_action(execWord[`CTRL_MSB:`CTRL_LSB]) : ACT_NONE;

    function automatic logic [31:0] read_mux(input logic [7:0] addr, input front_state_type s);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (addr == `CMD_OFFSET) begin
            d = {16'h0000, s.lastWord};
        end else if (addr == `HOLD_OFFSET) begin
            d = {19'h00000, s.holdCode};
        end else if (addr == `OUT_OFFSET) begin
            d = {19'h00000, s.outCode};
        end else if (addr == `STAT_OFFSET) begin
            d[`STAT_SHUT_BIT] = s.shutdown;
            d[`STAT_SETTLED_BIT] = s.settled;
        end
        return d;
    endfunction : read_mux

    always_comb begin
        st_next = st_reg;
        st_next.syncSel = {st_reg.syncSel[2:0], selectN};
        st_next.syncTog = {st_reg.syncTog[1:0], wordToggle};
        if (selRise) begin
            st_next.wordSeen = 1'b0;
        end else if (togChange) begin
            st_next.wordSeen = 1'b1;
        end

        if (execSerial | execApb) begin
            st_next.lastWord = execWord;
        end

        // settle timer: restarts on power-up and on every shutdown exit
        if (st_reg.shutdown) begin
            st_next.settleCnt = 8'h00;
            st_next.settled = 1'b0;
        end else if (st_reg.settleCnt != SETTLE_COUNT) begin
            st_next.settleCnt = st_reg.settleCnt + 8'h01;
            st_next.settled = (st_reg.settleCnt == (SETTLE_COUNT - 8'h01));
        end

        unique case (act)
            ACT_NONE: begin
            end
            ACT_LOAD_BOTH: begin
                st_next.holdCode = execWord[`CODE_MSB:0];
                st_next.outCode = execWord[`CODE_MSB:0];
                st_next.shutdown = 1'b0;
            end
            ACT_LOAD_HOLD: begin
                st_next.holdCode = execWord[`CODE_MSB:0];
            end
            ACT_RECALL: begin
                st_next.outCode = st_reg.holdCode;
                st_next.shutdown = 1'b0;
            end
            ACT_SHUTDOWN: begin
                st_next.shutdown = 1'b1;
                st_next.settleCnt = 8'h00;
                st_next.settled = 1'b0;
            end
        endcase

        // a shutdown exit restarts the settle wait even if already counting
        if (st_reg.shutdown && !st_next.shutdown) begin
            st_next.settleCnt = 8'h00;
            st_next.settled = 1'b0;
        end

        // read data is prepared in setup and refreshed while the access stalls
        if (apbReq.psel && !(apbReq.penable && apbResp.pready)) begin
            st_next.readData = apbReq.pwrite ? 32'h0000_0000 : read_mux(apbReq.paddr, st_reg);
            st_next.readErr = ~addrHit;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.syncSel <= 4'hf;
            st_reg.holdCode <= `CODE_RESET;
            st_reg.outCode <= `CODE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apbResp.pready = ~execSerial;
    assign apbResp.pslverr = st_reg.readErr & apbAccess;
    assign apbResp.prdata = st_reg.readData;

    assign analogCtrl.level = st_reg.outCode;
    assign analogCtrl.outputDisable = st_reg.shutdown;
    assign analogCtrl.refDisable = st_reg.shutdown;
    assign analogCtrl.settled = st_reg.settled;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence seq_exec(action_type a);
        (execSerial | execApb) && act == a;
    endsequence

    sequence seq_sel_close;
        selRise;
    endsequence

    property prop_recall;
        seq_exec(ACT_RECALL) |=> st_reg.outCode == $past(st_reg.holdCode)
            && !analogCtrl.outputDisable;
    endproperty

    property prop_load_both;
        seq_exec(ACT_LOAD_BOTH) |=> analogCtrl.level.codeBits == $past(execWord[12:3])
            && st_reg.holdCode == $past(execWord[12:0]) && !st_reg.shutdown;
    endproperty

    chk_zero_code_start: assert property (@(posedge mclk) $rose(reset_n) |->
        st_reg.holdCode == 13'h0000 && st_reg.outCode == 13'h0000)
        else $error("codes not zero after reset");

    chk_shutdown_entry: assert property (seq_exec(ACT_SHUTDOWN) |=>
        analogCtrl.outputDisable && analogCtrl.refDisable && $stable(st_reg.outCode))
        else $error("shutdown command not obeyed");

    chk_disable_level: assert property (st_reg.shutdown |->
        analogCtrl.outputDisable && analogCtrl.refDisable && !analogCtrl.settled)
        else $error("output enabled during shutdown");

    chk_hold_kept: assert property (st_reg.shutdown && act != ACT_LOAD_HOLD
        && act != ACT_LOAD_BOTH |=> $stable(st_reg.holdCode))
        else $error("holding code lost in shutdown");

    chk_recall_path: assert property (prop_recall)
        else $error("recall did not copy holding code");

    chk_load_both: assert property (prop_load_both)
        else $error("direct load wrong");

    chk_hold_only: assert property (seq_exec(ACT_LOAD_HOLD) |=>
        $stable(st_reg.outCode) && st_reg.holdCode == $past(execWord[12:0]))
        else $error("holding load touched output");

    chk_partial_drop: assert property (selRise && !st_reg.wordSeen && !togChange
        && !execApb |=> $stable(st_reg.holdCode) && $stable(st_reg.outCode)
        && $stable(st_reg.shutdown))
        else $error("partial word changed state");

    chk_exec_on_rise: assert property (togChange ##[1:3] seq_sel_close |-> execSerial)
        else $error("finished word not executed at select rise");

    chk_serial_in_sd: assert property (st_reg.shutdown && execSerial
        && execWord[14:13] == 2'h1 |=> st_reg.holdCode == $past(wordHold[12:0]))
        else $error("serial word ignored in shutdown");

    chk_settle_wait: assert property ($fell(st_reg.shutdown) |->
        !analogCtrl.settled [*8] ##1 (st_reg.settleCnt < SETTLE_COUNT))
        else $error("settle flag too early");

    // a word is finished once its toggle has been seen and remembered
    sequence seq_word_done;
        togChange ##1 st_reg.wordSeen;
    endsequence

    sequence seq_leave_shutdown;
        st_reg.shutdown ##1 !st_reg.shutdown;
    endsequence

    // raw control bits under a mask, so these checks do not lean on the decoder
    sequence seq_ctrl(logic [2:0] c, logic [2:0] m);
        (execSerial | execApb) && (execWord[`CTRL_MSB:`CTRL_LSB] & m) == c;
    endsequence

    property prop_nop_quiet;
        seq_ctrl(3'h3, 3'h7) |=>
            $stable(st_reg.holdCode) && $stable(st_reg.outCode) && $stable(st_reg.shutdown);
    endproperty

    chk_nop_quiet: assert property (prop_nop_quiet)
        else $error("no-operation word changed state");

    property prop_hold_no_exit;
        seq_ctrl(3'h1, 3'h3) |=>
            $stable(st_reg.shutdown) && $stable(st_reg.outCode);
    endproperty

    chk_hold_no_exit: assert property (prop_hold_no_exit)
        else $error("holding load changed shutdown or output");

    property prop_sd_keeps_hold;
        seq_ctrl(3'h7, 3'h7) |=>
            $stable(st_reg.holdCode) && st_reg.shutdown;
    endproperty

    chk_sd_keeps_hold: assert property (prop_sd_keeps_hold)
        else $error("shutdown entry lost holding code");

    property prop_recall_keeps;
        seq_ctrl(3'h2, 3'h3) |=>
            $stable(st_reg.holdCode) && !st_reg.shutdown;
    endproperty

    chk_recall_keeps: assert property (prop_recall_keeps)
        else $error("recall disturbed holding code");

    property prop_sd_unsettle;
        seq_ctrl(3'h7, 3'h7) |=>
            !analogCtrl.settled && analogCtrl.outputDisable && analogCtrl.refDisable;
    endproperty

    chk_sd_unsettle: assert property (prop_sd_unsettle)
        else $error("shutdown left output settled or enabled");

    property prop_exit_restart;
        seq_leave_shutdown |->
            st_reg.settleCnt == 8'h00 && !analogCtrl.settled;
    endproperty

    chk_exit_restart: assert property (prop_exit_restart)
        else $error("settle wait not restarted on shutdown exit");

    property prop_settle_done;
        st_reg.settleCnt == SETTLE_COUNT && !st_reg.shutdown |->
            analogCtrl.settled;
    endproperty

    chk_settle_done: assert property (prop_settle_done)
        else $error("settle flag missing after wait");

    property prop_one_exec;
        execSerial |=>
            !execSerial;
    endproperty

    chk_one_exec: assert property (prop_one_exec)
        else $error("one frame executed twice");

    property prop_serial_word;
        execSerial |=>
            st_reg.lastWord == $past(wordHold);
    endproperty

    chk_serial_word: assert property (prop_serial_word)
        else $error("executed serial word not recorded");

    property prop_cmd_word;
        execApb |=>
            st_reg.lastWord == $past(apbReq.pwdata[15:0]);
    endproperty

    chk_cmd_word: assert property (prop_cmd_word)
        else $error("register command word not recorded");

    // the bus is held off in the one cycle a serial word executes
    property prop_stall_exec;
        seq_word_done ##[0:2] seq_sel_close |->
            !apbResp.pready;
    endproperty

    chk_stall_exec: assert property (prop_stall_exec)
        else $error("bus not stalled during serial execution");

    property prop_bad_addr;
        apbAccess && !addrHit |->
            apbResp.pslverr && apbResp.prdata == 32'h0000_0000;
    endproperty

    chk_bad_addr: assert property (prop_bad_addr)
        else $error("unmapped access not flagged");

    property prop_power_up;
        $rose(reset_n) |->
            !st_reg.shutdown && !analogCtrl.settled && st_reg.settleCnt == 8'h00;
    endproperty

    chk_power_up: assert property (prop_power_up)
        else $error("state not cleared at power-up");
endmodule : serial_dac_command_front_end

// File: testbench/host_link_model.sv
// Purpose: host side of the serial link: select, data and link clock
// Assumes: link clock of 12 ns that only runs inside a frame
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ps
module host_link_model (
    output logic linkClk,
    output logic selectN,
    output logic dataIn
);
    initial begin
        linkClk = 1'b0;
        selectN = 1'b1;
        dataIn = 1'b0;
    end

    // n below 16 closes the frame early on purpose
    task automatic send(input logic [15:0] w, input int n);
        #3 selectN = 1'b0;
        #40;
        for (int i = 15; i > 15 - n; i--) begin
            dataIn = w[i];
            #6 linkClk = 1'b1;
            #6 linkClk = 1'b0;
        end
        #6 selectN = 1'b1;
        dataIn = ~dataIn;
    endtask : send
endmodule : host_link_model

// File: testbench/tb.sv
// Purpose: self-checking bench of the dac command front end
// Assumes: host model drives the link, the bench drives apb
// Notes: reads note the expected word in a queue, a monitor compares
`timescale 1ns/1ps
`include "dac_front_map.svh"
module tb import dac_front_pkg::*;;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic e;
    } exp_type;
    logic mclk, reset_n, linkClk, selectN, dataIn, shut, wasShut;
    apb_req_type apbReq;
    apb_resp_type apbResp;
    analog_ctrl_type analogCtrl;
    exp_type expQ[$];
    exp_type ent;
    int num_errors, checks;
    logic [31:0] rng = 32'h8441985a;
    logic [31:0] r;
    logic [12:0] hold, outv;
    logic [15:0] w;
    logic [2:0] cmds [10] = '{3'h0, 3'h5, 3'h7, 3'h1, 3'h6, 3'h3, 3'h4, 3'h7, 3'h2, 3'h0};

    serial_dac_command_front_end dut_u (.mclk(mclk), .reset_n(reset_n), .linkClk(linkClk),
        .selectN(selectN), .dataIn(dataIn), .apbReq(apbReq), .apbResp(apbResp),
        .analogCtrl(analogCtrl));
    host_link_model host_u (.linkClk(linkClk), .selectN(selectN), .dataIn(dataIn));

    always #50 mclk = ~mclk;

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    task automatic compare(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : compare

    task automatic print_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // entered just after a rising edge; leaves one idle edge so psel is never set twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (apbResp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            print_verdict();
        end
        apbReq <= '0;
        @(posedge mclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic e);
        expQ.push_back('{d, m, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    always @(posedge mclk) begin
        if (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbResp.pready === 1'b1
            && expQ.size() > 0) begin
            ent = expQ.pop_front();
            compare("prdata", apbResp.prdata & ent.m, ent.d);
            compare("pslverr", {31'h0, apbResp.pslverr}, {31'h0, ent.e});
        end
    end

    // close waits out the sync latency and the idle gap between frames
    task automatic frame(input logic [15:0] v, input int n);
        host_u.send(v, n);
        repeat (8) @(posedge mclk);
    endtask : frame

    task automatic model(input logic [15:0] v);
        case (v[14:13])
            2'h0: begin
                hold = v[12:0];
                outv = v[12:0];
                shut = 1'b0;
            end
            2'h1: hold = v[12:0];
            2'h2: begin
                outv = hold;
                shut = 1'b0;
            end
            default: if (v[15]) shut = 1'b1;
        endcase
    endtask : model

    task automatic check_all();
        rd(`HOLD_OFFSET, {19'h0, hold}, 32'hffffffff, 1'b0);
        rd(`OUT_OFFSET, {19'h0, outv}, 32'hffffffff, 1'b0);
        rd(`STAT_OFFSET, {31'h0, shut}, 32'h1, 1'b0);
        compare("level", {19'h0, analogCtrl.level}, {19'h0, outv});
        compare("outputDisable", {31'h0, analogCtrl.outputDisable}, {31'h0, shut});
        compare("refDisable", {31'h0, analogCtrl.refDisable}, {31'h0, shut});
    endtask : check_all

    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        print_verdict();
    end

    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        apbReq = '0;
        {hold, outv, shut} = '0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (250) @(posedge mclk);
        rd(`STAT_OFFSET, 32'h2, 32'h3, 1'b0);
        check_all();
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            r = xs();
            w = {cmds[i], (i == 0) ? 10'h3ff : r[9:0], 3'h0};
            wasShut = shut;
            frame(w, 16);
            model(w);
            if (wasShut && !shut) begin
                compare("settled", {31'h0, analogCtrl.settled}, 32'h0);
                repeat (210) @(posedge mclk);
                compare("settled", {31'h0, analogCtrl.settled}, 32'h1);
            end
            check_all();
            $display("test command %h done", w[15:13]);
        end
        // a short frame carrying a load-both code must leave everything alone
        frame({3'h0, ~outv[12:3], 3'h0}, 10);
        check_all();
        $display("test partial frame done");
        r = xs();
        w = {3'h0, r[9:0], 3'h0};
        apb(1'b1, `CMD_OFFSET, {16'h0, w});
        model(w);
        repeat (4) @(posedge mclk);
        check_all();
        rd(`CMD_OFFSET, {16'h0, w}, 32'hffff, 1'b0);
        rd(8'h10, 32'h0, 32'hffffffff, 1'b1);
        $display("test register path done");
        repeat (2) @(posedge mclk);
        print_verdict();
    end
endmodule : tb
